// [adc_flow_config_control_tb.sv]
`timescale 1ns/10ps
module adc_flow_config_control_tb;
  import afcc_pkg::*;
  typedef struct {int due; bit sel; logic [15:0] m; logic [15:0] e;} afcc_note_t;
  logic clock_in, rstn_in, reg_wr_in, converter_enable_in, special_mode_in;
  logic stop_mode_in, wait_mode_in, restart_event_in, abort_event_in, sequence_abort_bit_in;
  logic conv_active_in, conv_boundary_in, last_conv_in, list_done_in, cmd_started_in;
  logic bus_cmd_wr_in, bus_flow_wr_in, intf_flow_wr_in;
  logic [2:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, d;
  logic flow_mode_select_out, command_list_buffer_mode_out, result_list_buffer_mode_out;
  logic special_access_out, bus_flow_wr_ok_out, intf_flow_wr_ok_out, cmd_wr_ok_out;
  logic store_result_out, discard_result_out, restart_error_flag_out, set_abort_out;
  logic auto_restart_event_out, conv_halt_out, err;
  wire [12:0] fl = {flow_mode_select_out, command_list_buffer_mode_out,
    result_list_buffer_mode_out, special_access_out, bus_flow_wr_ok_out,
    intf_flow_wr_ok_out, cmd_wr_ok_out, store_result_out, discard_result_out,
    restart_error_flag_out, set_abort_out, auto_restart_event_out, conv_halt_out};
  afcc_note_t q[$];
  afcc_note_t n;
  int cyc = 0, miscompares = 0, n_compared = 0;
  logic [5:0] ev_tab [6] = '{6'h24, 6'h14, 6'h26, 6'h2C, 6'h20, 6'h21};
  afcc_top dut (.clock_in, .rstn_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .converter_enable_in, .special_mode_in, .stop_mode_in,
    .wait_mode_in, .bus_flow_wr_in, .intf_flow_wr_in, .restart_event_in,
    .abort_event_in, .sequence_abort_bit_in, .conv_active_in, .conv_boundary_in,
    .last_conv_in, .list_done_in, .cmd_started_in, .bus_cmd_wr_in,
    .flow_mode_select_out, .command_list_buffer_mode_out, .result_list_buffer_mode_out,
    .special_access_out, .bus_flow_wr_ok_out, .intf_flow_wr_ok_out, .cmd_wr_ok_out,
    .store_result_out, .discard_result_out, .restart_error_flag_out, .set_abort_out,
    .auto_restart_event_out, .conv_halt_out);
  afcc_partner p (.bus_flow_wr_out(bus_flow_wr_in), .intf_flow_wr_out(intf_flow_wr_in));
  // ----------------------------------------------------------------
  // clock, cycle count and scoreboard
  // ----------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // pulses are only checked on the cycle the note names
  always @(negedge clock_in)
    while (q.size() > 0 && q[0].due == cyc)
    begin
      n = q.pop_front();
      if (n.sel)
        cmp("flags", n.e, {3'h0, fl} & n.m);
      else
        cmp("rdata", n.e, reg_rdata_out & n.m);
    end
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic step(input int k = 1);
    repeat (k) @(posedge clock_in) #1;
  endtask
  task automatic ck(input bit s, input logic [15:0] m, input logic [15:0] e, input int lat);
    q.push_back(afcc_note_t'{cyc + lat, s, m, e & m});
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    step();
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    step();
    reg_wr_in = 1'b0;
    step(3);
  endtask
  task automatic w1(input logic en, input logic sm, input logic [7:0] v, input logic [7:0] e);
    converter_enable_in = en;
    special_mode_in = sm;
    wr(AFCC_CTL1_OFS, {8'h00, v});
    ck(0, 16'h00F0, {8'h00, e}, 0);
    ck(1, 16'h0E00, {4'h0, e[7:5], 9'h000}, 0);
  endtask
  task automatic cw(input logic st, input logic e);
    step();
    cmd_started_in = st;
    bus_cmd_wr_in = 1'b1;
    ck(1, 16'h0040, {9'h000, e, 6'h00}, 1);
    step();
    bus_cmd_wr_in = 1'b0;
  endtask
  task automatic mode_exit(input bit stp, input logic e, input logic h);
    step();
    if (stp) stop_mode_in = 1'b1;
    else wait_mode_in = 1'b1;
    step(4);
    ck(1, 16'h0001, {15'h0000, h}, 0);
    step();
    {stop_mode_in, wait_mode_in} = 2'b00;
    ck(1, 16'h0002, {14'h0000, e, 1'b0}, 1);
    ck(1, 16'h0002, 16'h0000, 2);
  endtask
  task automatic end_sim();
    if (q.size() > 0)
    begin
      miscompares++;
      $display("mismatch pending_notes expected %0d seen %0d", 0, q.size());
    end
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rstn_in, reg_wr_in, converter_enable_in, special_mode_in, stop_mode_in} = 5'h00;
    {wait_mode_in, restart_event_in, abort_event_in, sequence_abort_bit_in} = 4'h0;
    {conv_active_in, conv_boundary_in, last_conv_in, list_done_in} = 4'h0;
    {cmd_started_in, bus_cmd_wr_in} = 2'b00;
    reg_addr_in = 3'h0;
    reg_wdata_in = 16'h0000;
    void'($urandom(60));
    step(2);
    rstn_in = 1'b1;
    step(3);
    ck(0, 16'hFFFF, AFCC_CTL0_RESET, 0);
    ck(1, 16'h1FFF, 16'h0000, 0);
    step(2);
    reg_addr_in = AFCC_CTL1_OFS;
    step(3);
    ck(0, 16'h00FF, {8'h00, AFCC_CTL1_RESET}, 0);
    for (int a = 0; a < 4; a++)
    begin
      d = 16'($urandom());
      d[12:10] = {1'b0, 2'(a)};
      wr(AFCC_CTL0_OFS, d);
      ck(0, 16'h1F00, d, 0);
      ck(1, 16'h1000, {3'h0, d[8], 12'h000}, 0);
      step();
      p.drive(1'b1, 1'b1);
      ck(1, 16'h0180, {7'h00, 2'(a), 7'h00}, 1);
      step();
      p.drive(1'b0, 1'b0);
    end
    // second reset with non-zero configuration held
    step();
    rstn_in = 1'b0;
    step(2);
    rstn_in = 1'b1;
    step(3);
    ck(0, 16'hFFFF, AFCC_CTL0_RESET, 0);
    ck(1, 16'h1FFF, 16'h0000, 0);
    for (int s = 0; s < 2; s++)
    begin
      wr(AFCC_CTL0_OFS, {6'h00, 1'(s), 9'h000});
      foreach (ev_tab[i])
      begin
        step();
        {restart_event_in, abort_event_in, sequence_abort_bit_in, conv_active_in,
          last_conv_in, list_done_in} = ev_tab[i];
        d[0] = ev_tab[i][2] & (ev_tab[i][5] | ev_tab[i][4]);
        err = ev_tab[i][5] & !ev_tab[i][4] & !ev_tab[i][3] & !ev_tab[i][0]
          & !(s[0] & ev_tab[i][1] & ev_tab[i][2]);
        ck(1, 16'h003C, {10'h000, s[0] & d[0], !s[0] & d[0], err, err, 2'b00}, 1);
        step();
        {restart_event_in, abort_event_in, sequence_abort_bit_in, conv_active_in,
          last_conv_in, list_done_in} = 6'h00;
      end
    end
    w1(1'b1, 1'b0, 8'hF0, 8'h10);
    w1(1'b0, 1'b0, 8'hD0, 8'hD0);
    w1(1'b1, 1'b0, 8'h00, 8'hC0);
    w1(1'b1, 1'b1, 8'h20, 8'hE0);
    w1(1'b1, 1'b1, 8'h30, 8'h30);
    cw(1'b0, 1'b1);
    cw(1'b1, 1'b0);
    w1(1'b1, 1'b0, 8'h10, 8'h10);
    cw(1'b0, 1'b0);
    cmd_started_in = 1'b0;
    wr(AFCC_CTL0_OFS, 16'h1000);
    mode_exit(1'b1, 1'b1, 1'b0);
    mode_exit(1'b0, 1'b1, 1'b1);
    // a busy converter only halts at its next boundary
    step(2);
    {conv_active_in, wait_mode_in} = 2'b11;
    ck(1, 16'h0001, 16'h0000, 1);
    step(2);
    conv_boundary_in = 1'b1;
    ck(1, 16'h0001, 16'h0001, 1);
    step();
    {conv_boundary_in, wait_mode_in, conv_active_in} = 3'b000;
    wr(AFCC_CTL0_OFS, 16'h0000);
    mode_exit(1'b0, 1'b0, 1'b0);
    wr(AFCC_CTL1_OFS, 16'h0000);
    mode_exit(1'b1, 1'b0, 1'b0);
    step(3);
    end_sim();
  end
endmodule

// [afcc_event.sv]
`timescale 1ns/10ps
// decides result storage and restart-error handling for one abort/restart event
module afcc_event
  import afcc_pkg::*;
(
  // configuration
  input wire logic store_on_abort_in,
  // event and conversion state
  input wire logic restart_event_in,
  input wire logic abort_event_in,
  input wire logic sequence_abort_bit_in,
  input wire logic conv_active_in,
  input wire logic last_conv_in,
  input wire logic list_done_in,
  // decisions
  output logic store_result_out,
  output logic discard_result_out,
  output logic restart_error_out
);
  logic any_event;
  logic lone_restart;
  logic early_restart;
  assign any_event = restart_event_in | abort_event_in;
  assign lone_restart = restart_event_in & ~abort_event_in & ~sequence_abort_bit_in;
  // early: list not finished and (when storing) not inside the final conversion
  assign early_restart = lone_restart & ~list_done_in &
    ~(store_on_abort_in & last_conv_in & conv_active_in);
  assign store_result_out = any_event & conv_active_in & store_on_abort_in; // [R4]
  assign discard_result_out = any_event & conv_active_in & ~store_on_abort_in; // [R2]
  // [R3] [R5] [R6]
  assign restart_error_out = store_on_abort_in ? early_restart
                                               : (lone_restart & ~list_done_in);
endmodule

// [afcc_partner.sv]
`timescale 1ns/10ps
// far side: bus and internal interface issuing flow control writes
module afcc_partner
(
  // requests toward the block
  output logic bus_flow_wr_out,
  output logic intf_flow_wr_out
);
  initial
  begin
    bus_flow_wr_out = 1'b0;
    intf_flow_wr_out = 1'b0;
  end
  // both paths may fire in the same cycle, as a dual access user would
  task automatic drive(input logic b, input logic i);
    bus_flow_wr_out = b;
    intf_flow_wr_out = i;
  endtask
endmodule

// [afcc_pkg.sv]
package afcc_pkg;
  // register offsets
  localparam logic [2:0] AFCC_CTL0_OFS = 3'h0;
  localparam logic [2:0] AFCC_CTL1_OFS = 3'h1;
  // converter_control_zero fields (16 bit)
  localparam int AFCC_ACC_HI_POS = 11;
  localparam int AFCC_ACC_LO_POS = 10;
  localparam int AFCC_WAIT_HALT_POS = 12;
  localparam int AFCC_STORE_POS = 9;
  localparam int AFCC_MODE_POS = 8;
  // converter_control_one fields (8 bit)
  localparam int AFCC_COMMAND_LIST_BUFFER_MODE_POS = 7;
  localparam int AFCC_RESULT_LIST_BUFFER_MODE_POS = 6;
  localparam int AFCC_SPECIAL_POS = 5;
  localparam int AFCC_AUTO_RESTART_BIT_POS = 4;
  // reset values
  localparam logic [15:0] AFCC_CTL0_RESET = 16'h0000;
  localparam logic [7:0] AFCC_CTL1_RESET = 8'h00;
  // access configuration codes
  localparam logic [1:0] AFCC_ACC_NONE = 2'h0;
  localparam logic [1:0] AFCC_ACC_INTF = 2'h1;
  localparam logic [1:0] AFCC_ACC_BUS = 2'h2;
  localparam logic [1:0] AFCC_ACC_BOTH = 2'h3;
endpackage

// [afcc_top.sv]
`timescale 1ns/10ps
// Behaviour
// R1: two-bit field picks flow control access path: none, interface, bus, both.
// R2: storage bit clear: event during conversion discards result, complete flag stays clear.
// R3: storage bit clear: early lone restart sets restart error and abort bit.
// R4: storage bit set: event during conversion stores result, sets flag, updates info.
// R5: storage bit set: lone restart in final conversion gives no restart error.
// R6: storage bit set: lone restart before list finishes sets error and abort bit.
// R7: flow mode bit selects restart mode at 0, trigger mode at 1.
// R8: software or interface drives flow control bits as the mode requires.
// R9: buffer mode bits writable only while disabled or special access set.
// R10: special access writable only in special mode, cleared on leaving it.
// R11: special access lifts per-bit write restrictions; otherwise normal user access.
// R12: special access lets bus overwrite current command only before it starts.
// R13: command list buffer mode: single when clear, double when set.
// R14: result list buffer mode: single when clear, double when set.
// R15: auto-restart issues restart after stop exit or wait exit with halt set.
// R16: auto-restart bit writable at any time.
// R17: wait-halt set halts conversion at next boundary on wait entry.
// R18: flow control writes through a disabled path are ignored.
// R19: all configuration bits reset to zero.
module afcc_top
  import afcc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // register port
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // chip mode and enable
  input wire logic converter_enable_in,
  input wire logic special_mode_in,
  input wire logic stop_mode_in,
  input wire logic wait_mode_in,
  // flow control write requests from the two paths
  input wire logic bus_flow_wr_in,
  input wire logic intf_flow_wr_in,
  // conversion sequencer status
  input wire logic restart_event_in,
  input wire logic abort_event_in,
  input wire logic sequence_abort_bit_in,
  input wire logic conv_active_in,
  input wire logic conv_boundary_in,
  input wire logic last_conv_in,
  input wire logic list_done_in,
  input wire logic cmd_started_in,
  input wire logic bus_cmd_wr_in,
  // outputs
  output logic flow_mode_select_out,
  output logic command_list_buffer_mode_out,
  output logic result_list_buffer_mode_out,
  output logic special_access_out,
  output logic bus_flow_wr_ok_out,
  output logic intf_flow_wr_ok_out,
  output logic cmd_wr_ok_out,
  output logic store_result_out,
  output logic discard_result_out,
  output logic restart_error_flag_out,
  output logic set_abort_out,
  output logic auto_restart_event_out,
  output logic conv_halt_out
);
  import afcc_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic rstn;
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rstn = rst_sync_reg[1];

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [15:0] ctl0_reg;
  logic [15:0] ctl0_next;
  logic [7:0] ctl1_reg;
  logic [7:0] ctl1_next;
  logic wr_ctl0;
  logic wr_ctl1;
  logic restricted_ok;
  logic special_prev_reg;
  logic special_exit;
  logic [7:0] wbyte;

  assign wr_ctl0 = reg_wr_in & (reg_addr_in == AFCC_CTL0_OFS);
  assign wr_ctl1 = reg_wr_in & (reg_addr_in == AFCC_CTL1_OFS);
  assign restricted_ok = ~converter_enable_in | ctl1_reg[AFCC_SPECIAL_POS]; // [R9] [R11]
  assign special_exit = special_prev_reg & ~special_mode_in; // [R10]
  assign wbyte = reg_wdata_in[7:0];

  // only the fields of this block are kept; other bits read as zero
  always_comb
  begin
    ctl0_next = ctl0_reg;
    if (wr_ctl0)
    begin
      ctl0_next[AFCC_ACC_HI_POS] = reg_wdata_in[AFCC_ACC_HI_POS]; // [R1]
      ctl0_next[AFCC_ACC_LO_POS] = reg_wdata_in[AFCC_ACC_LO_POS]; // [R1]
      ctl0_next[AFCC_WAIT_HALT_POS] = reg_wdata_in[AFCC_WAIT_HALT_POS];
      ctl0_next[AFCC_STORE_POS] = reg_wdata_in[AFCC_STORE_POS];
      ctl0_next[AFCC_MODE_POS] = reg_wdata_in[AFCC_MODE_POS]; // [R7]
    end
  end

  always_comb
  begin
    ctl1_next = ctl1_reg;
    if (wr_ctl1)
    begin
      if (restricted_ok)
      begin
        ctl1_next[AFCC_COMMAND_LIST_BUFFER_MODE_POS] = wbyte[AFCC_COMMAND_LIST_BUFFER_MODE_POS]; // [R9] [R13]
        ctl1_next[AFCC_RESULT_LIST_BUFFER_MODE_POS] = wbyte[AFCC_RESULT_LIST_BUFFER_MODE_POS]; // [R9] [R14]
      end
      if (special_mode_in)
        ctl1_next[AFCC_SPECIAL_POS] = wbyte[AFCC_SPECIAL_POS]; // [R10]
      ctl1_next[AFCC_AUTO_RESTART_BIT_POS] = wbyte[AFCC_AUTO_RESTART_BIT_POS]; // [R16]
    end
    // leaving special mode wins over a write in the same cycle
    if (special_exit || !special_mode_in)
      ctl1_next[AFCC_SPECIAL_POS] = 1'b0; // [R10]
  end

  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl0_reg <= AFCC_CTL0_RESET; // [R19]
      ctl1_reg <= AFCC_CTL1_RESET; // [R19]
      special_prev_reg <= 1'b0;
    end
    else
    begin
      ctl0_reg <= ctl0_next;
      ctl1_reg <= ctl1_next;
      special_prev_reg <= special_mode_in;
    end
  end

  // ----------------------------------------
  // flow control access gating
  // ----------------------------------------
  logic [1:0] acc_sel;
  logic bus_ok;
  logic intf_ok;
  assign acc_sel = {ctl0_reg[AFCC_ACC_HI_POS], ctl0_reg[AFCC_ACC_LO_POS]};
  assign bus_ok = bus_flow_wr_in & acc_sel[1]; // [R1] [R18]
  assign intf_ok = intf_flow_wr_in & acc_sel[0]; // [R1] [R18]
  // [R12] a command already converting must not be overwritten
  logic cmd_ok;
  assign cmd_ok = bus_cmd_wr_in & ctl1_reg[AFCC_SPECIAL_POS] & ~cmd_started_in;

  // ----------------------------------------
  // abort and restart event handling
  // ----------------------------------------
  logic ev_store;
  logic ev_discard;
  logic ev_error;
  afcc_event u_event (
    .store_on_abort_in(ctl0_reg[AFCC_STORE_POS]),
    .restart_event_in(restart_event_in),
    .abort_event_in(abort_event_in),
    .sequence_abort_bit_in(sequence_abort_bit_in),
    .conv_active_in(conv_active_in),
    .last_conv_in(last_conv_in),
    .list_done_in(list_done_in),
    .store_result_out(ev_store),
    .discard_result_out(ev_discard),
    .restart_error_out(ev_error)
  );

  // ----------------------------------------
  // stop / wait exit and halt
  // ----------------------------------------
  logic stop_prev_reg;
  logic wait_prev_reg;
  logic mode_exit;
  logic halt_next;
  logic halt_reg;
  // wait exit only counts when the wait-halt bit is set
  assign mode_exit = (stop_prev_reg & ~stop_mode_in) |
    (wait_prev_reg & ~wait_mode_in & ctl0_reg[AFCC_WAIT_HALT_POS]); // [R15]
  assign halt_next = (wait_mode_in & ctl0_reg[AFCC_WAIT_HALT_POS]) ?
    (halt_reg | conv_boundary_in | ~conv_active_in) : 1'b0; // [R17]

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      stop_prev_reg <= 1'b0;
      wait_prev_reg <= 1'b0;
      halt_reg <= 1'b0;
      reg_rdata_out <= 16'h0000;
      flow_mode_select_out <= 1'b0;
      command_list_buffer_mode_out <= 1'b0;
      result_list_buffer_mode_out <= 1'b0;
      special_access_out <= 1'b0;
      bus_flow_wr_ok_out <= 1'b0;
      intf_flow_wr_ok_out <= 1'b0;
      cmd_wr_ok_out <= 1'b0;
      store_result_out <= 1'b0;
      discard_result_out <= 1'b0;
      restart_error_flag_out <= 1'b0;
      set_abort_out <= 1'b0;
      auto_restart_event_out <= 1'b0;
      conv_halt_out <= 1'b0;
    end
    else
    begin
      stop_prev_reg <= stop_mode_in;
      wait_prev_reg <= wait_mode_in;
      halt_reg <= halt_next;
      reg_rdata_out <= (reg_addr_in == AFCC_CTL0_OFS) ? ctl0_reg :
        (reg_addr_in == AFCC_CTL1_OFS) ? {8'h00, ctl1_reg} : 16'h0000;
      flow_mode_select_out <= ctl0_reg[AFCC_MODE_POS]; // [R7]
      command_list_buffer_mode_out <= ctl1_reg[AFCC_COMMAND_LIST_BUFFER_MODE_POS]; // [R13]
      result_list_buffer_mode_out <= ctl1_reg[AFCC_RESULT_LIST_BUFFER_MODE_POS]; // [R14]
      special_access_out <= ctl1_reg[AFCC_SPECIAL_POS]; // [R11]
      bus_flow_wr_ok_out <= bus_ok; // [R18]
      intf_flow_wr_ok_out <= intf_ok; // [R18]
      cmd_wr_ok_out <= cmd_ok; // [R12]
      store_result_out <= ev_store; // [R4]
      discard_result_out <= ev_discard; // [R2]
      restart_error_flag_out <= ev_error; // [R3] [R6]
      set_abort_out <= ev_error; // [R3] [R6]
      auto_restart_event_out <= mode_exit & ctl1_reg[AFCC_AUTO_RESTART_BIT_POS]; // [R15]
      conv_halt_out <= halt_next; // [R17]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_bus_path_gate: assert property (@(posedge clock_in) disable iff (!rstn) // [R18]
    bus_flow_wr_in && !acc_sel[1] |=> !bus_flow_wr_ok_out)
    else $error("bus flow write passed while bus path disabled");
  a_intf_path_gate: assert property (@(posedge clock_in) disable iff (!rstn) // [R1]
    intf_flow_wr_in && acc_sel[0] |=> intf_flow_wr_ok_out)
    else $error("interface flow write not passed while enabled");
  a_bmod_locked: assert property (@(posedge clock_in) disable iff (!rstn) // [R9]
    wr_ctl1 && converter_enable_in && !ctl1_reg[AFCC_SPECIAL_POS]
    |=> $stable(ctl1_reg[AFCC_COMMAND_LIST_BUFFER_MODE_POS]) && $stable(ctl1_reg[AFCC_RESULT_LIST_BUFFER_MODE_POS]))
    else $error("buffer mode changed while locked");
  a_special_clear: assert property (@(posedge clock_in) disable iff (!rstn) // [R10]
    !special_mode_in |=> !ctl1_reg[AFCC_SPECIAL_POS])
    else $error("special access held outside special mode");
  a_auto_restart_bit_wr: assert property (@(posedge clock_in) disable iff (!rstn) // [R16]
    wr_ctl1 |=> ctl1_reg[AFCC_AUTO_RESTART_BIT_POS] == $past(wbyte[AFCC_AUTO_RESTART_BIT_POS]))
    else $error("auto restart write lost");
  a_discard_event: assert property (@(posedge clock_in) disable iff (!rstn) // [R2]
    restart_event_in && conv_active_in && !ctl0_reg[AFCC_STORE_POS]
    |=> discard_result_out && !store_result_out)
    else $error("result not discarded");
  a_store_event: assert property (@(posedge clock_in) disable iff (!rstn) // [R4]
    abort_event_in && conv_active_in && ctl0_reg[AFCC_STORE_POS]
    |=> store_result_out && !discard_result_out)
    else $error("result not stored");
  a_last_no_error: assert property (@(posedge clock_in) disable iff (!rstn) // [R5]
    ctl0_reg[AFCC_STORE_POS] && last_conv_in && conv_active_in |=> !restart_error_flag_out)
    else $error("restart error in final conversion");
  a_early_error: assert property (@(posedge clock_in) disable iff (!rstn) // [R3]
    restart_event_in && !abort_event_in && !sequence_abort_bit_in && !list_done_in
    && !last_conv_in |=> restart_error_flag_out && set_abort_out)
    else $error("early restart not flagged");
  a_cmd_started: assert property (@(posedge clock_in) disable iff (!rstn) // [R12]
    cmd_started_in |=> !cmd_wr_ok_out)
    else $error("command overwritten after start");
  a_auto_restart: assert property (@(posedge clock_in) disable iff (!rstn) // [R15]
    stop_prev_reg && !stop_mode_in && ctl1_reg[AFCC_AUTO_RESTART_BIT_POS] |=> auto_restart_event_out)
    else $error("no automatic restart after stop exit");
  a_bus_path_open: assert property (@(posedge clock_in) disable iff (!rstn) // [R1]
    bus_flow_wr_in && acc_sel[1] |=> bus_flow_wr_ok_out)
    else $error("bus flow write not passed while enabled");
  a_cmd_gate: assert property (@(posedge clock_in) disable iff (!rstn) // [R12]
    bus_cmd_wr_in && ctl1_reg[AFCC_SPECIAL_POS] && !cmd_started_in |=> cmd_wr_ok_out)
    else $error("command write refused before start");
  a_wait_exit: assert property (@(posedge clock_in) disable iff (!rstn) // [R15]
    wait_prev_reg && !wait_mode_in && ctl0_reg[AFCC_WAIT_HALT_POS]
    && ctl1_reg[AFCC_AUTO_RESTART_BIT_POS] |=> auto_restart_event_out)
    else $error("no automatic restart after wait exit");
  a_no_auto: assert property (@(posedge clock_in) disable iff (!rstn) // [R15]
    !ctl1_reg[AFCC_AUTO_RESTART_BIT_POS] |=> !auto_restart_event_out)
    else $error("automatic restart while disabled");
  a_halt_idle: assert property (@(posedge clock_in) disable iff (!rstn) // [R17]
    wait_mode_in && ctl0_reg[AFCC_WAIT_HALT_POS] && !conv_active_in |=> conv_halt_out)
    else $error("idle converter not halted in wait mode");
  a_halt_boundary: assert property (@(posedge clock_in) disable iff (!rstn) // [R17]
    wait_mode_in && ctl0_reg[AFCC_WAIT_HALT_POS] && conv_active_in && !conv_boundary_in
    && !halt_reg |=> !conv_halt_out)
    else $error("conversion halted before its boundary");
  a_halt_off: assert property (@(posedge clock_in) disable iff (!rstn) // [R17]
    !wait_mode_in |=> !conv_halt_out)
    else $error("halt held outside wait mode");
endmodule
